//--- rtl/flash_prot_map.vh
// register addresses, keys and reset values of the flash protect and program block
`ifndef FLASH_PROT_MAP_VH
`define FLASH_PROT_MAP_VH
// ==========================================================
// register file addresses
`define FP_ADDR_CTRL      12'hFF8
`define FP_ADDR_PAGE      12'hFF9
// ==========================================================
// control register values
`define FP_KEY_PROTECT    8'h5E
`define FP_CMD_RESET      8'h00
`define FP_CMD_UNLOCK1    8'h73
`define FP_CMD_UNLOCK2    8'h8C
`define FP_CMD_PAGE_ERASE 8'h95
`define FP_CMD_MASS_ERASE 8'h63
// ==========================================================
// reset values and array figures
`define FP_PROT_RESET     8'h00
`define FP_PAGE_RESET     8'h00
`define FP_ERASED_BYTE    8'hFF
`define FP_PAGE_BITS      3
`define FP_OFFS_BITS      11
`define FP_PROG_CYCLES    4'h8
`endif

//--- rtl/flash_prog_timer.v
// cycle counter that times one byte program operation
module flash_prog_timer (
    input  wire       clk,
    input  wire       srst,
    input  wire       start,  // one-cycle start pulse
    output wire       busy    // high while counting
);
`include "flash_prot_map.vh"
    // ======================================================
    // countdown
    reg [3:0] cnt_q;  // cycles left
    always @(posedge clk) begin
        if (srst) begin
            cnt_q <= 4'h0;
        end else if (start) begin
            cnt_q <= `FP_PROG_CYCLES;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
    assign busy = (cnt_q != 4'h0);
endmodule

//--- rtl/flash_protect_prog.v
// flash sector protection, page select and byte programming sequencer
`include "flash_prot_map.vh"
// Behaviour
// - reset clears protection mask to zero
// - key 5EH maps mask onto page address
// - mask writes only set bits
// - other control values restore page select
// - protected sector refuses program and erase
// - program only active page when unlocked
// - erased reads FFH; program clears bits
// - processor stalls during byte program
// - page stays unlocked after a program
// - non-erase control write relocks flash
module flash_protect_prog (
    input  wire        clk,
    input  wire        srst,
    // register file port
    input  wire [11:0] reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    // program memory port from the processor
    input  wire [13:0] mem_addr,
    input  wire        mem_wr,
    input  wire [7:0]  mem_wdata,
    input  wire        mem_rd,
    output reg  [7:0]  mem_rdata,
    // status
    output wire        cpu_stall,
    output wire        unlocked,
    output wire        prot_select,
    output wire        refused,
    output wire [7:0]  sector_protect
);
    // ======================================================
    // state
    // unlock walk: locked, first key seen, open for programming
    // a wrong second key other than 73H or an erase code drops back to locked, so a
    // stray write from runaway code cannot open the array by luck
    // the fourth code is unused and decodes as locked
    localparam ST_LOCKED = 2'b00;
    localparam ST_KEY1   = 2'b01;
    localparam ST_OPEN   = 2'b10;

    reg [1:0]  st_q;        // unlock sequence state
    reg        sel_q;       // protect mask mapped at page address
    reg [7:0]  prot_q;      // sector protect mask
    reg [7:0]  page_q;      // page select
    reg        ref_q;       // last request was refused
    reg [7:0]  mem [0:16383]; // flash array
    reg [7:0]  mrd_q;
    reg [14:0] ers_q;       // erase walk pointer, bit 14 = busy
    reg        ers_all_q;   // mass erase in progress
    reg [7:0]  rdata_d;

    wire ctrl_wr = reg_wr && (reg_addr == `FP_ADDR_CTRL);
    wire page_wr = reg_wr && (reg_addr == `FP_ADDR_PAGE);
    wire [2:0] sector = mem_addr[13:11];
    wire       sect_prot = prot_q[sector];
    wire       prog_busy;
    wire       erasing = ers_q[14];
    wire is_erase = (reg_wdata == `FP_CMD_PAGE_ERASE) || (reg_wdata == `FP_CMD_MASS_ERASE);
    // program allowed: unlocked, active page, not protected
    wire prog_ok = (st_q == ST_OPEN) && (mem_addr[13:11] == page_q[2:0]) && !sect_prot;
    wire prog_go = mem_wr && !prog_busy && !erasing && prog_ok;
    wire page_ers_ok = (st_q == ST_OPEN) && !prot_q[page_q[2:0]];
    wire mass_ers_ok = (st_q == ST_OPEN) && (prot_q == 8'h00);
    // mass erase is all or nothing: one protected sector blocks it,
    // rather than erasing around the guarded sectors
    // page and sector share one numbering, so the page select low
    // bits name the sector that a page erase would touch
    // a program is not started during an erase walk, but an erase can start while the program timer runs

    // ======================================================
    // status outputs
    // stall covers both the program timer and the erase walk, so
    // the processor never fetches from an array that is changing
    // the mask is exported as is, for debug and for the checker
    // refused is a level and stays until the next accepted request
    // ======================================================
    // program timer
    // a fixed count stands in for the real cell programming time;
    // the timer ignores new starts only because prog_go is gated
    // by prog_busy here, not inside the timer itself
    flash_prog_timer u_timer (
        .clk   (clk),
        .srst  (srst),
        .start (prog_go),
        .busy  (prog_busy)
    );

    assign cpu_stall      = prog_busy || erasing;
    assign unlocked       = (st_q == ST_OPEN);
    assign prot_select    = sel_q;
    assign refused        = ref_q;
    assign sector_protect = prot_q;

    // ======================================================
    // control register, unlock and mask selection
    // every control write decides the mask selection afresh, so
    // any value but the key hands the shared address back to the
    // page select register
    // the mask only ever gains bits; only reset takes them away,
    // which keeps protection safe from a later bad write
    always @(posedge clk) begin
        if (srst) begin
            st_q   <= ST_LOCKED;
            sel_q  <= 1'b0;
            prot_q <= `FP_PROT_RESET;
            page_q <= `FP_PAGE_RESET;
        end else begin
            if (ctrl_wr) begin
                sel_q  <= (reg_wdata == `FP_KEY_PROTECT);
                // unlock sequence; any other non-erase write relocks
                if (reg_wdata == `FP_CMD_UNLOCK1) begin
                    st_q <= ST_KEY1;
                end else if (reg_wdata == `FP_CMD_UNLOCK2 && st_q == ST_KEY1) begin
                    st_q <= ST_OPEN;
                end else if (!is_erase) begin
                    st_q <= ST_LOCKED;
                end
            end
            if (page_wr) begin
                if (sel_q) begin
                    prot_q <= prot_q | reg_wdata;
                end else begin
                    page_q <= reg_wdata;
                end
            end
            // st_q untouched by a program: page stays open
        end
    end

    // ======================================================
    // flash array: program, erase walk, read
    // program is an and of old and new data: bits only fall
    // erase walks one byte per clock, so the array stays a plain
    // single write port memory; the price is a long stall
    // a program request during stall is dropped without a flag,
    // since the processor is held and cannot issue one anyway
    // array contents are not reset: software erases before use
    always @(posedge clk) begin
        if (srst) begin
            ers_q     <= 15'h0000;
            ers_all_q <= 1'b0;
            ref_q     <= 1'b0;
            mrd_q     <= 8'h00;
        end else begin
            if (prog_go) begin
                mem[mem_addr] <= mem[mem_addr] & mem_wdata;
                ref_q <= 1'b0;
            end else if (mem_wr && !prog_busy && !erasing) begin
                ref_q <= 1'b1;
            end
            if (ctrl_wr && is_erase && !erasing) begin
                if (reg_wdata == `FP_CMD_MASS_ERASE) begin
                    ref_q <= !mass_ers_ok;
                    if (mass_ers_ok) begin
                        ers_q     <= 15'h4000;
                        ers_all_q <= 1'b1;
                    end
                end else begin
                    ref_q <= !page_ers_ok;
                    if (page_ers_ok) begin
                        ers_q     <= {1'b1, page_q[2:0], 11'h000};
                        ers_all_q <= 1'b0;
                    end
                end
            end else if (erasing) begin
                mem[ers_q[13:0]] <= `FP_ERASED_BYTE;
                if ((ers_all_q && ers_q[13:0] == 14'h3FFF) ||
                    (!ers_all_q && ers_q[10:0] == 11'h7FF)) begin
                    ers_q <= 15'h0000;
                end else begin
                    ers_q <= ers_q + 15'h0001;
                end
            end
            if (mem_rd) begin
                mrd_q <= mem[mem_addr];
            end
        end
    end

    always @* begin
        mem_rdata = mrd_q;
    end

    // ======================================================
    // register read mux; shared address follows selection
    // control reads return status, not the last value written:
    // bit 2 refused, bit 1 programming, bit 0 unlocked
    // unknown addresses read zero
    always @* begin
        rdata_d = 8'h00;
        if (reg_addr == `FP_ADDR_CTRL) begin
            rdata_d = {5'h00, ref_q, prog_busy, unlocked};
        end else if (reg_addr == `FP_ADDR_PAGE) begin
            rdata_d = sel_q ? prot_q : page_q;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end
    end
endmodule

//--- sim/fpp_properties.sv
// checker for the flash protect and program block
module fpp_properties (
    input logic        clk, srst, reg_wr, reg_rd, mem_wr, mem_rd,
    input logic [11:0] reg_addr,
    input logic [13:0] mem_addr,
    input logic [7:0]  reg_wdata, reg_rdata, mem_wdata, mem_rdata,
    input logic        cpu_stall, unlocked, prot_select, refused,
    input logic [7:0]  sector_protect
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire ctl = reg_wr && reg_addr == 12'hFF8;
    wire go = mem_wr && !cpu_stall;
    // accepted program, then stall of 8
    sequence s_take; go ##1 !refused; endsequence
    sequence s_hold; cpu_stall [*8] ##1 !cpu_stall; endsequence
    a_mask_clear: assert property ($fell(srst) |-> sector_protect == 8'h00)
        else $error("mask not clear");
    a_key_select: assert property (ctl && reg_wdata == 8'h5E |=> prot_select)
        else $error("no select");
    a_mask_or: assert property (reg_wr && reg_addr == 12'hFF9 && prot_select |=>
        sector_protect == ($past(sector_protect) | $past(reg_wdata))) else $error("mask");
    a_bits_stick: assert property (!$past(srst) |->
        &(sector_protect | ~$past(sector_protect))) else $error("bit cleared");
    a_other_deselect: assert property (ctl && reg_wdata != 8'h5E |=> !prot_select)
        else $error("still selected");
    a_prot_refuse: assert property (go && sector_protect[mem_addr[13:11]] |=>
        refused && !cpu_stall) else $error("protected write");
    a_lock_refuse: assert property (go && !unlocked |=> refused && !cpu_stall)
        else $error("locked write");
    a_prog_stall: assert property (s_take |-> s_hold) else $error("stall");
    a_stay_open: assert property (s_take ##8 1 |-> unlocked) else $error("relocked");
    a_relock: assert property (ctl && reg_wdata == 8'h00 |=> !unlocked)
        else $error("not relocked");
endmodule
bind flash_protect_prog fpp_properties chk (.*);

//--- sim/flash_protect_prog_bench.sv
// bench for the flash protect and program block
module flash_protect_prog_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, mem_wr = 0, mem_rd = 0;
    logic [11:0] reg_addr = 0;
    logic [13:0] mem_addr = 0;
    logic [7:0] reg_wdata = 0, mem_wdata = 0, reg_rdata, mem_rdata, sector_protect;
    logic cpu_stall, unlocked, prot_select, refused, st;
    int bad_count = 0, checked = 0, cyc = 0;
    flash_protect_prog uut (.*);
    always #4 clk = ~clk;
    // cut a hang short
    always @(posedge clk) if (++cyc == 6000) begin
        bad_count++;
        end_sim;
    end
    task cmp(input logic [7:0] g, e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // bounded wait for the stall to drop
    task wt;
        for (int n = 0; n < 3000 && cpu_stall !== 1'b0; n++) @(negedge clk);
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk); reg_addr = a; reg_wdata = d; reg_wr = 1;
        @(negedge clk); reg_wr = 0; wt;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e);
        @(negedge clk); reg_addr = a; reg_rd = 1;
        @(negedge clk); reg_rd = 0; cmp(reg_rdata, e);
    endtask
    task mw(input logic [13:0] a, input logic [7:0] d);
        @(negedge clk); mem_addr = a; mem_wdata = d; mem_wr = 1;
        @(negedge clk); mem_wr = 0; st = cpu_stall; wt;
    endtask
    task mr(input logic [13:0] a, input logic [7:0] e);
        @(negedge clk); mem_addr = a; mem_rd = 1;
        @(negedge clk); mem_rd = 0; cmp(mem_rdata, e);
    endtask
    task t_prot;
        wr(12'hFF8, 8'h00); wr(12'hFF8, 8'h5E);
        cmp({7'h00, prot_select}, 8'h01);
        wr(12'hFF9, 8'h03); wr(12'hFF9, 8'h04);
        rd(12'hFF9, 8'h07);
        wr(12'hFF8, 8'h00);
        rd(12'hFF9, 8'h00);
        $display("protect test done");
    endtask
    task t_prog;
        wr(12'hFF8, 8'h73); wr(12'hFF8, 8'h8C); wr(12'hFF9, 8'h03);
        wr(12'hFF8, 8'h95);
        mr(14'h1801, 8'hFF);
        mw(14'h1801, 8'hA5);
        cmp({7'h00, st}, 8'h01);
        mw(14'h1801, 8'h0F);
        mr(14'h1801, 8'h05);
        cmp({7'h00, unlocked}, 8'h01);
        wr(12'hFF9, 8'h01);
        mw(14'h0802, 8'h00);
        cmp({7'h00, refused}, 8'h01);
        mw(14'h1801, 8'h00);
        mr(14'h1801, 8'h05);
        wr(12'hFF8, 8'h63);
        cmp({7'h00, refused}, 8'h01);
        rd(12'hFF8, 8'h05);
        wr(12'hFF8, 8'h00);
        cmp({7'h00, unlocked}, 8'h00);
        $display("program test done");
    endtask
    task t_rst;
        srst = 1;
        repeat (5) @(negedge clk);
        srst = 0;
        cmp(sector_protect, 8'h00);
        wr(12'hFF8, 8'h00); wr(12'hFF8, 8'h5E); wr(12'hFF9, 8'h10);
        rd(12'hFF9, 8'h10);
        wr(12'hFF8, 8'h00);
        $display("reset test done");
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        srst = 0;
        rd(12'hFF9, 8'h00);
        t_prot;
        t_prog;
        t_rst;
        end_sim;
    end
endmodule
